// file: design/hcb_bridge.sv
`timescale 1ns/100ps
// Overview of operation
// - Link uses clock, frame, five-bit bus, irq
// - Fifth bus bit carries nibble parity
// - Memory only, 16-bit address and data
// - Data four nibbles, least significant first
// - Turnaround: 1111 then release
// - Read phase order, up to 30 cycles
// - Write phase order, up to 30 cycles
// - 32-bit access is two link transactions
// - Card accesses behave like local ones
// - Card interrupts on separate active-low line
// - 512KB window, eight 32KB cards low
// - Unsupported requests get an error answer
// - Single-word requests, one bus transaction
// - Packet and user clocks, crossing between
// - 32-bit registers honor byte selects
// - Two master ports, host on port 0
// - Simultaneous: host first, else arrival order
// - Interrupt status register at 0x2C
module hcb_bridge (
  input wire logic clk,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic m0_cyc,
  input wire logic m0_we,
  input wire logic [18:0] m0_adr,
  input wire logic [31:0] m0_dat_w,
  input wire logic [3:0] m0_sel,
  output logic m0_ack,
  output logic m0_err,
  output logic [31:0] m0_dat_r,
  input wire logic m1_cyc,
  input wire logic m1_we,
  input wire logic [18:0] m1_adr,
  input wire logic [31:0] m1_dat_w,
  input wire logic [3:0] m1_sel,
  output logic m1_ack,
  output logic m1_err,
  output logic [31:0] m1_dat_r,
  output logic host_irq,
  output logic [2:0] link_card_sel,
  output logic link_frame_n,
  input wire logic [4:0] link_nibble_bus_in,
  output logic [4:0] link_nibble_bus_out,
  output logic link_nibble_bus_oe,
  input wire logic link_irq_n
);

  typedef struct packed {
    hcb_pkg::hcb_core_e state;
    logic gnt;
    logic older1;
    logic we;
    logic [31:0] wdat;
    logic [31:0] rd;
    logic [31:0] scratch;
    logic [1:0] irq_sts;
    logic [2:0] card;
    logic [15:0] link_addr;
    logic [15:0] link_wd;
    logic lerr;
    logic req_tgl;
    logic done_s1;
    logic done_s2;
    logic done_seen;
    logic irq_s1;
    logic irq_s2;
    logic ack;
    logic err;
  } hcb_core_s;

  typedef struct packed {
    hcb_pkg::hcb_link_e state;
    logic [3:0] cnt;
    logic req_s1;
    logic req_s2;
    logic req_seen;
    logic done_tgl;
    logic [15:0] rdat;
    logic err;
    logic frame_n;
    logic [4:0] nib_o;
    logic oe;
  } hcb_link_s;

  hcb_core_s st;
  hcb_core_s n;
  hcb_link_s sl;
  hcb_link_s nl;
  logic pick;
  logic accept;
  logic c_we;
  logic [18:0] c_adr;
  logic [31:0] c_dat;
  logic [3:0] c_sel;
  logic [17:0] gen_ofs;
  logic done_ev;
  logic [1:0] irq_clr;
  logic [3:0] ldat;

  // Byte-lane merge so single bytes can be written
  function automatic logic [31:0] hcb_merge(input logic [31:0] old,
                                            input logic [31:0] nw,
                                            input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction : hcb_merge

  // Even parity: fifth bit makes the five-bit count of ones even
  function automatic logic hcb_par(input logic [3:0] d);
    return ^d;
  endfunction : hcb_par

  // Arbitration: host wins a tie, otherwise the older requester
  always_comb begin
    pick = 1'b0;
    if (m1_cyc && (!m0_cyc || st.older1)) begin
      pick = 1'b1;
    end
    accept = (m0_cyc || m1_cyc) && !st.ack && !st.err &&
             (st.state == hcb_pkg::C_IDLE);
    c_we = pick ? m1_we : m0_we;
    c_adr = pick ? m1_adr : m0_adr;
    c_dat = pick ? m1_dat_w : m0_dat_w;
    c_sel = pick ? m1_sel : m0_sel;
    gen_ofs = c_adr[hcb_pkg::GEN_W-1:0];
    done_ev = st.done_s2 != st.done_seen;
  end

  // Core sequencer; one host word to card space becomes two link transfers
  always_comb begin
    n = st;
    irq_clr = 2'b00;
    n.ack = 1'b0;
    n.err = 1'b0;
    n.irq_s1 = link_irq_n;
    n.irq_s2 = st.irq_s1;
    n.done_s1 = sl.done_tgl;
    n.done_s2 = st.done_s1;
    // Port 1 is older only while it waits; an idle port 1 forgets it,
    // so a later same-cycle tie goes to the host port
    if (m1_cyc && !m0_cyc) begin
      n.older1 = 1'b1;
    end else if (!m1_cyc) begin
      n.older1 = 1'b0;
    end
    case (st.state)
      hcb_pkg::C_IDLE: begin
        if (accept) begin
          n.gnt = pick;
          n.we = c_we;
          n.wdat = c_dat;
          if (!c_adr[hcb_pkg::CARD_BIT]) begin
            // Card window: 32KB per card, low half first
            n.card = c_adr[hcb_pkg::CARD_MSB:hcb_pkg::CARD_LSB];
            n.link_addr = {1'b0, c_adr[14:2], 2'b00};
            n.link_wd = c_dat[15:0];
            n.lerr = 1'b0;
            n.req_tgl = ~st.req_tgl;
            n.state = hcb_pkg::C_LO;
          end else if (gen_ofs == hcb_pkg::GEN_SCRATCH_OFS) begin
            if (c_we) begin
              n.scratch = hcb_merge(st.scratch, c_dat, c_sel);
            end
            n.rd = st.scratch;
            n.ack = 1'b1;
          end else if (gen_ofs == hcb_pkg::GEN_IRQ_OFS) begin
            if (c_we && c_sel[0]) begin
              irq_clr = c_dat[1:0];
            end
            n.rd = {30'h0, st.irq_sts};
            n.ack = 1'b1;
          end else begin
            n.err = 1'b1;
          end
        end
      end
      hcb_pkg::C_LO: begin
        if (done_ev) begin
          // Second half follows at once, address plus two
          n.done_seen = st.done_s2;
          n.rd[15:0] = sl.rdat;
          n.lerr = sl.err;
          n.link_addr = st.link_addr | hcb_pkg::HALF_STEP;
          n.link_wd = st.wdat[31:16];
          n.req_tgl = ~st.req_tgl;
          n.state = hcb_pkg::C_HI;
        end
      end
      hcb_pkg::C_HI: begin
        if (done_ev) begin
          n.done_seen = st.done_s2;
          n.rd[31:16] = sl.rdat;
          n.err = st.lerr || sl.err;
          n.ack = !(st.lerr || sl.err);
          n.state = hcb_pkg::C_IDLE;
        end
      end
      default: begin
        n.state = hcb_pkg::C_IDLE;
      end
    endcase
    // Clear first so an event in the same cycle still sets the bit
    n.irq_sts = st.irq_sts & ~irq_clr;
    if (!st.irq_s2) begin
      n.irq_sts[hcb_pkg::IRQ_CARD_BIT] = 1'b1;
    end
    if (st.state == hcb_pkg::C_HI && done_ev && (st.lerr || sl.err)) begin
      n.irq_sts[hcb_pkg::IRQ_LINK_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
      st.state <= hcb_pkg::C_IDLE;
      st.scratch <= hcb_pkg::SCRATCH_RST;
      st.irq_sts <= hcb_pkg::IRQ_RST;
      st.irq_s1 <= 1'b1;
      st.irq_s2 <= 1'b1;
    end else begin
      st <= n;
    end
  end

  // Answers steered back to the granted master
  assign m0_ack = st.ack && !st.gnt;
  assign m1_ack = st.ack && st.gnt;
  assign m0_err = st.err && !st.gnt;
  assign m1_err = st.err && st.gnt;
  assign m0_dat_r = st.rd;
  assign m1_dat_r = st.rd;
  assign host_irq = |st.irq_sts;
  assign link_card_sel = st.card;

  // Link sequencer on the link clock; request fields stay still
  // while a toggle is outstanding, so they are read here directly
  always_comb begin
    nl = sl;
    nl.req_s1 = st.req_tgl;
    nl.req_s2 = sl.req_s1;
    nl.cnt = sl.cnt + 4'h1;
    case (sl.state)
      hcb_pkg::L_IDLE: begin
        nl.cnt = 4'h0;
        if (sl.req_s2 != sl.req_seen) begin
          nl.req_seen = sl.req_s2;
          nl.err = 1'b0;
          nl.state = hcb_pkg::L_START;
        end
      end
      hcb_pkg::L_START: begin
        nl.state = hcb_pkg::L_TYPE;
      end
      hcb_pkg::L_TYPE: begin
        nl.cnt = 4'h0;
        nl.state = hcb_pkg::L_ADDR;
      end
      hcb_pkg::L_ADDR: begin
        if (sl.cnt == hcb_pkg::ADDR_LAST) begin
          nl.cnt = 4'h0;
          nl.state = st.we ? hcb_pkg::L_WDATA : hcb_pkg::L_MTAR;
        end
      end
      hcb_pkg::L_WDATA: begin
        if (sl.cnt == hcb_pkg::DATA_LAST) begin
          nl.cnt = 4'h0;
          nl.state = hcb_pkg::L_MTAR;
        end
      end
      hcb_pkg::L_MTAR: begin
        if (sl.cnt == hcb_pkg::TAR_LAST) begin
          nl.cnt = 4'h0;
          nl.state = hcb_pkg::L_SYNC;
        end
      end
      hcb_pkg::L_SYNC: begin
        // Wait states are 0101; 0000 ends the wait
        if (link_nibble_bus_in[3:0] == hcb_pkg::NIB_READY) begin
          nl.cnt = 4'h0;
          nl.state = st.we ? hcb_pkg::L_STAR : hcb_pkg::L_RDATA;
        end else if (sl.cnt == hcb_pkg::SYNC_LIMIT ||
                     link_nibble_bus_in[3:0] != hcb_pkg::NIB_WAIT) begin
          nl.err = 1'b1; // Silent card must not hang the host
          nl.cnt = 4'h0;
          nl.state = hcb_pkg::L_STAR;
        end
        if (link_nibble_bus_in[4] != hcb_par(link_nibble_bus_in[3:0])) begin
          nl.err = 1'b1;
        end
      end
      hcb_pkg::L_RDATA: begin
        nl.rdat[4*sl.cnt[1:0] +: 4] = link_nibble_bus_in[3:0];
        if (link_nibble_bus_in[4] != hcb_par(link_nibble_bus_in[3:0])) begin
          nl.err = 1'b1;
        end
        if (sl.cnt == hcb_pkg::DATA_LAST) begin
          nl.cnt = 4'h0;
          nl.state = hcb_pkg::L_STAR;
        end
      end
      hcb_pkg::L_STAR: begin
        if (sl.cnt == hcb_pkg::TAR_LAST) begin
          nl.done_tgl = ~sl.done_tgl;
          nl.state = hcb_pkg::L_IDLE;
        end
      end
      default: begin
        nl.state = hcb_pkg::L_IDLE;
      end
    endcase
    // Pin values follow the next phase so they leave flip-flops
    ldat = hcb_pkg::NIB_TAR;
    nl.oe = 1'b0;
    nl.frame_n = nl.state != hcb_pkg::L_START;
    case (nl.state)
      hcb_pkg::L_START: begin
        ldat = hcb_pkg::NIB_START;
        nl.oe = 1'b1;
      end
      hcb_pkg::L_TYPE: begin
        ldat = st.we ? hcb_pkg::TYPE_WR : hcb_pkg::TYPE_RD;
        nl.oe = 1'b1;
      end
      hcb_pkg::L_ADDR: begin
        ldat = st.link_addr[4*(3-nl.cnt[1:0]) +: 4];
        nl.oe = 1'b1;
      end
      hcb_pkg::L_WDATA: begin
        ldat = st.link_wd[4*nl.cnt[1:0] +: 4];
        nl.oe = 1'b1;
      end
      hcb_pkg::L_MTAR: begin
        nl.oe = nl.cnt == 4'h0;
      end
      default: begin
        nl.oe = 1'b0;
      end
    endcase
    nl.nib_o = {hcb_par(ldat), ldat};
  end

  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      sl <= '0;
      sl.state <= hcb_pkg::L_IDLE;
      sl.frame_n <= 1'b1;
    end else begin
      sl <= nl;
    end
  end

  // Eight link wires: clock, frame, five-bit bus, interrupt
  assign link_frame_n = sl.frame_n;
  assign link_nibble_bus_out = sl.nib_o;
  assign link_nibble_bus_oe = sl.oe;

  sequence s_start;
    !link_frame_n && link_nibble_bus_oe;
  endsequence
  property p_frame_one;
    @(posedge link_clk) disable iff (rst)
      !link_frame_n |=> link_frame_n;
  endproperty
  a_frame_one: assert property (p_frame_one)
    else $error("frame low longer than one cycle");
  property p_start_code;
    @(posedge link_clk) disable iff (rst)
      s_start |-> link_nibble_bus_out[3:0] == 4'h0;
  endproperty
  a_start_code: assert property (p_start_code)
    else $error("start nibble not zero");
  property p_type_code;
    @(posedge link_clk) disable iff (rst)
      s_start |=> link_nibble_bus_oe && (link_nibble_bus_out[3:0] == 4'h4
      || link_nibble_bus_out[3:0] == 4'h6);
  endproperty
  a_type_code: assert property (p_type_code)
    else $error("bad cycle type after start");
  property p_addr_len;
    @(posedge link_clk) disable iff (rst)
      s_start |=> ##1 (link_nibble_bus_oe && link_frame_n)[*4];
  endproperty
  a_addr_len: assert property (p_addr_len)
    else $error("address phase not four driven cycles");
  property p_parity;
    @(posedge link_clk) disable iff (rst)
      link_nibble_bus_oe |-> !(^link_nibble_bus_out);
  endproperty
  a_parity: assert property (p_parity)
    else $error("odd parity on driven nibble");
  sequence s_mtar;
    sl.state == hcb_pkg::L_MTAR && sl.cnt == 4'h0;
  endsequence
  property p_tar;
    @(posedge link_clk) disable iff (rst)
      s_mtar |-> link_nibble_bus_out[3:0] == 4'hf ##1 !link_nibble_bus_oe;
  endproperty
  a_tar: assert property (p_tar)
    else $error("turnaround not 1111 then release");
  property p_half_step;
    @(posedge clk) disable iff (rst)
      ($past(st.state) == hcb_pkg::C_LO && st.state == hcb_pkg::C_HI)
      |-> st.link_addr[1] && st.req_tgl != $past(st.req_tgl);
  endproperty
  a_half_step: assert property (p_half_step)
    else $error("second half transfer not issued");
  property p_prio;
    @(posedge clk) disable iff (rst)
      (accept && m0_cyc && m1_cyc && !st.older1) |=> !st.gnt;
  endproperty
  a_prio: assert property (p_prio)
    else $error("host master lost a tie");
  property p_unmapped;
    @(posedge clk) disable iff (rst)
      (accept && c_adr[18] && gen_ofs != 18'h0 && gen_ofs != 18'h2c)
      |=> st.err && !st.ack;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access not refused");

endmodule : hcb_bridge

// file: design/hcb_pkg.sv
package hcb_pkg;
  // Host window is 512KB; bit 18 splits card space from general registers
  localparam int ADDR_W = 19;
  localparam int CARD_BIT = 18;
  localparam int CARD_MSB = 17;
  localparam int CARD_LSB = 15;
  localparam int GEN_W = 18;
  localparam int LINK_AW = 16;
  localparam int NIB_W = 5;
  // General register offsets inside the upper half
  localparam logic [17:0] GEN_SCRATCH_OFS = 18'h00000;
  localparam logic [17:0] GEN_IRQ_OFS = 18'h0002c;
  localparam logic [31:0] SCRATCH_RST = 32'h00000000;
  localparam logic [1:0] IRQ_RST = 2'h0;
  localparam int IRQ_CARD_BIT = 0;
  localparam int IRQ_LINK_BIT = 1;
  // Link phase codes
  localparam logic [3:0] NIB_START = 4'h0;
  localparam logic [3:0] TYPE_RD = 4'h4;
  localparam logic [3:0] TYPE_WR = 4'h6;
  localparam logic [3:0] NIB_TAR = 4'hf;
  localparam logic [3:0] NIB_READY = 4'h0;
  localparam logic [3:0] NIB_WAIT = 4'h5;
  // Phase lengths as last count index; half-word address step
  localparam logic [3:0] ADDR_LAST = 4'h3;
  localparam logic [3:0] DATA_LAST = 4'h3;
  localparam logic [3:0] TAR_LAST = 4'h1;
  localparam logic [3:0] SYNC_LIMIT = 4'hf;
  localparam logic [15:0] HALF_STEP = 16'h0002;

  typedef enum logic [1:0] {
    C_IDLE = 2'b00,
    C_LO = 2'b01,
    C_HI = 2'b10
  } hcb_core_e;

  typedef enum logic [3:0] {
    L_IDLE = 4'b0000,
    L_START = 4'b0001,
    L_TYPE = 4'b0010,
    L_ADDR = 4'b0011,
    L_WDATA = 4'b0100,
    L_MTAR = 4'b0101,
    L_SYNC = 4'b0110,
    L_RDATA = 4'b0111,
    L_STAR = 4'b1000
  } hcb_link_e;
endpackage : hcb_pkg

// file: testbench/hcb_bridge_bench.sv
`timescale 1ns/100ps
module hcb_bridge_bench;
  localparam logic [18:0] SCR = 19'h40000;
  localparam logic [18:0] IRQ = 19'h4002c;
  localparam logic [18:0] CARD = 19'h28124;
  logic clk;
  logic rst;
  logic link_clk;
  logic cyc [2];
  logic we [2];
  logic [18:0] adr [2];
  logic [31:0] wd [2];
  logic [3:0] sel [2];
  logic ack [2];
  logic err [2];
  logic [31:0] rd [2];
  logic host_irq;
  logic [2:0] card_sel;
  logic frame_n;
  logic [4:0] nib_in;
  logic [4:0] nib_out;
  logic oe;
  logic irq_n;
  logic irq_req;
  logic bad_par;
  logic [3:0] waits;
  logic [15:0] last_adr;
  logic [15:0] last_dat;
  logic [31:0] r;
  logic e;
  int n_xact;
  int n_proto;
  int n_mismatch;
  int n_tests;
  int cycles;

  hcb_bridge dut_u (
    .clk(clk), .rst(rst), .link_clk(link_clk),
    .m0_cyc(cyc[0]), .m0_we(we[0]), .m0_adr(adr[0]), .m0_dat_w(wd[0]),
    .m0_sel(sel[0]), .m0_ack(ack[0]), .m0_err(err[0]), .m0_dat_r(rd[0]),
    .m1_cyc(cyc[1]), .m1_we(we[1]), .m1_adr(adr[1]), .m1_dat_w(wd[1]),
    .m1_sel(sel[1]), .m1_ack(ack[1]), .m1_err(err[1]), .m1_dat_r(rd[1]),
    .host_irq(host_irq), .link_card_sel(card_sel), .link_frame_n(frame_n),
    .link_nibble_bus_in(nib_in), .link_nibble_bus_out(nib_out),
    .link_nibble_bus_oe(oe), .link_irq_n(irq_n)
  );

  hcb_card_model card_u (
    .link_clk(link_clk), .card_sel(card_sel), .frame_n(frame_n),
    .m_out(nib_out), .m_oe(oe), .bus(nib_in), .irq_n(irq_n),
    .irq_req(irq_req), .waits(waits), .bad_par(bad_par), .n_xact(n_xact),
    .n_proto(n_proto), .last_adr(last_adr), .last_dat(last_dat)
  );

  // Periods of 40 and 48 ns keep the link edges wandering against the core edges
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #24 link_clk = ~link_clk;
  end

  // Hang guard: a card access costs well under 200 core cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Request held until ack or err is seen; released on that edge
  task automatic bus(input int p, input logic w, input logic [18:0] a,
                     input logic [31:0] d, input logic [3:0] s,
                     output logic [31:0] rv, output logic ev);
    int k;
    @(posedge clk);
    cyc[p] <= 1'b1;
    we[p] <= w;
    adr[p] <= a;
    wd[p] <= d;
    sel[p] <= s;
    for (k = 0; k < 3000; k++) begin
      @(posedge clk);
      if (ack[p] === 1'b1 || err[p] === 1'b1)
        break;
    end
    rv = rd[p];
    ev = err[p];
    if (k == 3000)
      check("bus answer", 32'h0, 32'h1);
    cyc[p] <= 1'b0;
  endtask : bus

  task automatic t_reset();
    check("frame idle", frame_n, 32'h1);
    check("bus released", oe, 32'h0);
    check("ack idle", ack[0], 32'h0);
    check("irq idle", host_irq, 32'h0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_scratch();
    bus(0, 1'b1, SCR, 32'h11223344, 4'hf, r, e);
    bus(1, 1'b1, SCR, 32'haabbccdd, 4'h5, r, e);
    bus(0, 1'b0, SCR, 32'h0, 4'hf, r, e);
    check("scratch bytes", r, 32'h11bb33dd);
    bus(1, 1'b0, 19'h40010, 32'h0, 4'hf, r, e);
    check("unmapped err", e, 32'h1);
    $display("test scratch done");
  endtask : t_scratch

  // Card word write then slow-sync read-back from the other port
  task automatic t_card();
    int x0;
    x0 = n_xact;
    bus(0, 1'b1, CARD, 32'hcafe1234, 4'hf, r, e);
    check("card write err", e, 32'h0);
    check("halves", 32'(n_xact - x0), 32'h2);
    check("link addr", last_adr, 32'h0126);
    check("link data", last_dat, 32'hcafe);
    check("card index", card_sel, 32'h5);
    waits <= 4'h9;
    bus(1, 1'b0, CARD, 32'h0, 4'hf, r, e);
    check("card read", r, 32'hcafe1234);
    waits <= 4'h3;
    $display("test card done");
  endtask : t_card

  // Bad parity on read data; status bit then cleared by writing one
  task automatic t_parity();
    bad_par <= 1'b1;
    bus(0, 1'b0, CARD, 32'h0, 4'hf, r, e);
    bad_par <= 1'b0;
    check("parity err", e, 32'h1);
    check("irq level", host_irq, 32'h1);
    bus(0, 1'b0, IRQ, 32'h0, 4'hf, r, e);
    check("status link", r, 32'h2);
    bus(0, 1'b1, IRQ, 32'h3, 4'h1, r, e);
    bus(0, 1'b0, IRQ, 32'h0, 4'hf, r, e);
    check("status clear", r, 32'h0);
    $display("test parity done");
  endtask : t_parity

  // Card interrupt: a clear while still asserted must not stick
  task automatic t_irq();
    @(posedge clk);
    irq_req <= 1'b1;
    repeat (8) @(posedge clk);
    check("card irq", host_irq, 32'h1);
    bus(1, 1'b1, IRQ, 32'h1, 4'h1, r, e);
    bus(1, 1'b0, IRQ, 32'h0, 4'hf, r, e);
    check("status held", r, 32'h1);
    irq_req <= 1'b0;
    repeat (8) @(posedge clk);
    bus(1, 1'b1, IRQ, 32'h1, 4'h1, r, e);
    check("irq dropped", host_irq, 32'h0);
    $display("test irq done");
  endtask : t_irq

  // Both ports ask on the same edge; host port must win
  task automatic t_tie();
    time t0;
    time t1;
    logic [31:0] r0;
    logic [31:0] r1;
    logic e0;
    logic e1;
    fork
      begin
        bus(0, 1'b0, SCR, 32'h0, 4'hf, r0, e0);
        t0 = $time;
      end
      begin
        bus(1, 1'b0, SCR, 32'h0, 4'hf, r1, e1);
        t1 = $time;
      end
    join
    check("host first", 32'(t0 < t1), 32'h1);
    check("tie data", r1, 32'h11bb33dd);
    check("link wire", 32'(n_proto), 32'h0);
    $display("test tie done");
  endtask : t_tie

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : print_verdict

  initial begin
    n_mismatch = 0;
    n_tests = 0;
    cycles = 0;
    rst = 1'b1;
    irq_req = 1'b0;
    bad_par = 1'b0;
    waits = 4'h3;
    for (int i = 0; i < 2; i++) begin
      cyc[i] = 1'b0;
      we[i] = 1'b0;
      adr[i] = 19'h00000;
      wd[i] = 32'h0;
      sel[i] = 4'h0;
    end
    repeat (12) @(posedge clk);
    t_reset();
    rst <= 1'b0;
    t_scratch();
    t_card();
    t_parity();
    t_irq();
    t_tie();
    print_verdict();
  end
endmodule : hcb_bridge_bench

// file: testbench/hcb_card_model.sv
`timescale 1ns/100ps
// Card end of the link: a slave with a word store and a wire checker
module hcb_card_model (
  input wire logic link_clk,
  input wire logic [2:0] card_sel,
  input wire logic frame_n,
  input wire logic [4:0] m_out,
  input wire logic m_oe,
  output logic [4:0] bus,
  output logic irq_n,
  input wire logic irq_req,
  input wire logic [3:0] waits,
  input wire logic bad_par,
  output int n_xact,
  output int n_proto,
  output logic [15:0] last_adr,
  output logic [15:0] last_dat
);
  logic [15:0] mem [logic [18:0]];
  logic [4:0] drv = 5'h1f;
  logic drv_en = 1'b0;
  logic [3:0] typ;
  logic [3:0] n;
  logic [15:0] a;
  logic [15:0] d;

  // Nobody driving: pull-ups take the lines high, never the old value
  assign bus = m_oe ? m_out : (drv_en ? drv : 5'h1f);
  assign irq_n = ~irq_req;

  // One master cycle: frame high, master driving, even parity
  task automatic mcyc(output logic [3:0] v);
    @(posedge link_clk);
    v = m_out[3:0];
    if (frame_n !== 1'b1 || m_oe !== 1'b1 || ^m_out !== 1'b0)
      n_proto++;
  endtask : mcyc

  // One slave cycle; the master must stay off the lines meanwhile
  task automatic scyc(input logic [3:0] v, input logic flip);
    drv <= {^v ^ flip, v};
    drv_en <= 1'b1;
    @(posedge link_clk);
    if (m_oe !== 1'b0)
      n_proto++;
  endtask : scyc

  // Transaction walk, stepping one link cycle at a time
  initial begin
    n_xact = 0;
    n_proto = 0;
    last_adr = 16'h0000;
    last_dat = 16'h0000;
    forever begin
      @(posedge link_clk);
      if (m_oe === 1'b1 && frame_n === 1'b0) begin
        if (m_out !== 5'h00)
          n_proto++;
        mcyc(typ);
        for (int i = 0; i < 4; i++) begin
          mcyc(n);
          a = {a[11:0], n};
        end
        if (typ == 4'h6) begin
          for (int i = 0; i < 4; i++) begin
            mcyc(n);
            d = {n, d[15:4]};
          end
        end else if (typ != 4'h4)
          n_proto++;
        mcyc(n);
        if (n !== 4'hf)
          n_proto++;
        @(posedge link_clk);
        if (m_oe !== 1'b0)
          n_proto++;
        for (int i = 0; i < waits; i++)
          scyc(4'h5, 1'b0);
        scyc(4'h0, 1'b0);
        if (typ == 4'h4) begin
          d = mem.exists({card_sel, a}) ? mem[{card_sel, a}] : 16'h0000;
          for (int i = 0; i < 4; i++)
            scyc(d[4*i+:4], bad_par && i == 0);
        end else
          mem[{card_sel, a}] = d;
        scyc(4'hf, 1'b0);
        drv_en <= 1'b0;
        last_adr = a;
        last_dat = d;
        n_xact++;
      end
    end
  end
endmodule : hcb_card_model
